//--- rtl/uart_autobaud_wake_on_break.sv
// Serial port receive helper: auto-baud calibration and wake-on-break
`timescale 1ns/100ps
`default_nettype none

module uart_autobaud_wake_on_break (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_line,
  output logic receive_flag,
  output logic receive_idle_flag,
  output logic receiver_held_idle,
  output logic bit_rate_tick
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic autobaud_enable_reg; // Calibration requested
  logic wake_on_break_enable_reg; // Wake monitor armed
  logic wide_divisor_select_reg; // 16-bit divisor mode
  logic high_speed_select_reg; // High speed prescale
  logic sync_mode_reg; // Synchronous mode, blocks wake
  logic [7:0] rate_divisor_low_reg; // Low divisor byte
  logic [7:0] rate_divisor_high_reg; // High divisor byte
  logic [7:0] receive_data_reg; // Receive data, no data path here
  logic [15:0] rate_count_reg; // Bit rate down counter
  logic [2:0] edge_count_reg; // Rising edges seen in calibration
  autobaud_pkg::cal_state_t cal_state_reg; // Calibration sequencer
  autobaud_pkg::wake_state_t wake_state_reg; // Wake monitor
  logic base_tick; // Rate generator base clock tick
  logic cal_tick; // Calibration clock tick
  logic line_level; // Registered line level
  logic line_rise; // Line low to high
  logic line_fall; // Line high to low
  logic bus_write; // Write completes this edge
  logic bus_read; // Read completes this edge
  logic ctrl_write; // Write to rate control
  logic rx_data_read; // Read of receive data
  logic cal_done; // Fifth rising edge seen
  logic wake_event; // Falling edge while armed
  logic break_end; // Rising edge ending the break
  logic addr_ok; // Address maps to a register
  logic [31:0] read_mux; // Read data before the output flop
  logic [15:0] reload_value; // Divisor as seen by the rate generator

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  // Prescaler for base and calibration ticks
  rate_tick_gen u_ticks (
    .clk_sys(clk_sys),
    .rst(rst),
    .wide_divisor_select(wide_divisor_select_reg),
    .high_speed_select(high_speed_select_reg),
    .sync_mode(sync_mode_reg),
    .base_tick(base_tick),
    .cal_tick(cal_tick)
  );

  // Serial line edges
  line_edge_detect u_edges (
    .clk_sys(clk_sys),
    .rst(rst),
    .serial_in_line(serial_in_line),
    .line_level(line_level),
    .line_rise(line_rise),
    .line_fall(line_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  // A transfer completes in the access cycle; pready comes one cycle after setup
  assign bus_write = psel && penable && pready && pwrite;
  assign bus_read = psel && penable && pready && !pwrite;
  assign ctrl_write = bus_write && (paddr == autobaud_pkg::rate_control_off);
  assign rx_data_read = bus_read && (paddr == autobaud_pkg::receive_data_off);

  // Address decode and read data
  always_comb begin
    addr_ok = 1'b1;
    read_mux = 32'h00000000;
    if (paddr == autobaud_pkg::rate_control_off) begin
      read_mux[autobaud_pkg::autobaud_enable_bit] = autobaud_enable_reg;
      read_mux[autobaud_pkg::wake_on_break_enable_bit] = wake_on_break_enable_reg;
      read_mux[autobaud_pkg::wide_divisor_select_bit] = wide_divisor_select_reg;
      read_mux[autobaud_pkg::high_speed_select_bit] = high_speed_select_reg;
      read_mux[autobaud_pkg::sync_mode_bit] = sync_mode_reg;
    end else if (paddr == autobaud_pkg::status_off) begin
      read_mux[autobaud_pkg::receive_flag_bit] = receive_flag;
      read_mux[autobaud_pkg::receive_idle_flag_bit] = receive_idle_flag;
      read_mux[autobaud_pkg::calibrating_bit] = (cal_state_reg == autobaud_pkg::cal_count);
    end else if (paddr == autobaud_pkg::divisor_low_off) begin
      read_mux[7:0] = rate_divisor_low_reg;
    end else if (paddr == autobaud_pkg::divisor_high_off) begin
      read_mux[7:0] = rate_divisor_high_reg;
    end else if (paddr == autobaud_pkg::receive_data_off) begin
      read_mux[7:0] = receive_data_reg;
    end else begin
      addr_ok = 1'b0; // Unmapped: error answer, zero data
    end
  end

  // Handshake and registered answer, sampled in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? read_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate control register

  // Mode selects, plain software fields
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wide_divisor_select_reg <= autobaud_pkg::rate_control_reset[2];
      high_speed_select_reg <= autobaud_pkg::rate_control_reset[3];
      sync_mode_reg <= autobaud_pkg::rate_control_reset[4];
    end else if (ctrl_write) begin
      wide_divisor_select_reg <= pwdata[autobaud_pkg::wide_divisor_select_bit];
      high_speed_select_reg <= pwdata[autobaud_pkg::high_speed_select_bit];
      sync_mode_reg <= pwdata[autobaud_pkg::sync_mode_bit];
    end
  end

  // Autobaud enable; completion clear beats a same-cycle write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      autobaud_enable_reg <= autobaud_pkg::rate_control_reset[0];
    end else if (cal_done) begin
      autobaud_enable_reg <= 1'b0;
    end else if (ctrl_write) begin
      autobaud_enable_reg <= pwdata[autobaud_pkg::autobaud_enable_bit];
    end
  end

  // Wake enable; only accepted with asynchronous mode written alongside
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_on_break_enable_reg <= autobaud_pkg::rate_control_reset[1];
    end else if (break_end || sync_mode_reg) begin
      wake_on_break_enable_reg <= 1'b0;
    end else if (ctrl_write) begin
      wake_on_break_enable_reg <= pwdata[autobaud_pkg::wake_on_break_enable_bit]
        && !pwdata[autobaud_pkg::sync_mode_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration sequencer

  assign cal_done = (cal_state_reg == autobaud_pkg::cal_count) && line_rise
    && (edge_count_reg == autobaud_pkg::sync_rising_edges - 3'h1);

  // Wait start bit, then first rise, then count to the fifth rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_state_reg <= autobaud_pkg::cal_off;
    end else if (!autobaud_enable_reg) begin
      cal_state_reg <= autobaud_pkg::cal_off;
    end else begin
      case (cal_state_reg)
        autobaud_pkg::cal_off: begin
          cal_state_reg <= autobaud_pkg::cal_arm;
        end
        autobaud_pkg::cal_arm: begin
          // The break belongs to the wake monitor, never measured
          if (line_fall && !wake_on_break_enable_reg) begin
            cal_state_reg <= autobaud_pkg::cal_first_rise;
          end
        end
        autobaud_pkg::cal_first_rise: begin
          if (line_rise) begin
            cal_state_reg <= autobaud_pkg::cal_count;
          end
        end
        autobaud_pkg::cal_count: begin
          if (cal_done) begin
            cal_state_reg <= autobaud_pkg::cal_off;
          end
        end
        default: begin
          cal_state_reg <= autobaud_pkg::cal_off;
        end
      endcase
    end
  end

  // Rising edges counted from the first one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edge_count_reg <= 3'h0;
    end else if (cal_state_reg == autobaud_pkg::cal_first_rise && line_rise) begin
      edge_count_reg <= 3'h1;
    end else if (cal_state_reg == autobaud_pkg::cal_count && line_rise) begin
      edge_count_reg <= edge_count_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divisor pair: software register or calibration counter

  // Calibration owns the pair; software writes then are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rate_divisor_low_reg <= autobaud_pkg::divisor_reset;
      rate_divisor_high_reg <= autobaud_pkg::divisor_reset;
    end else if (cal_state_reg == autobaud_pkg::cal_first_rise && line_rise) begin
      {rate_divisor_high_reg, rate_divisor_low_reg} <= autobaud_pkg::cal_start_count;
    end else if (cal_state_reg == autobaud_pkg::cal_count) begin
      // Both bytes count together whatever the wide select says; wraps on overflow
      if (cal_tick && !cal_done) begin
        {rate_divisor_high_reg, rate_divisor_low_reg} <=
          {rate_divisor_high_reg, rate_divisor_low_reg} + 16'h0001;
      end
    end else if (bus_write && paddr == autobaud_pkg::divisor_low_off) begin
      rate_divisor_low_reg <= pwdata[7:0];
    end else if (bus_write && paddr == autobaud_pkg::divisor_high_off) begin
      rate_divisor_high_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit rate generator

  // Narrow modes ignore the high byte
  assign reload_value = wide_divisor_select_reg
    ? {rate_divisor_high_reg, rate_divisor_low_reg}
    : {8'h00, rate_divisor_low_reg};

  // Divisor plus one base ticks per bit; stopped while the line times it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rate_count_reg <= 16'h0000;
      bit_rate_tick <= 1'b0;
    end else if (autobaud_enable_reg) begin
      rate_count_reg <= 16'h0000;
      bit_rate_tick <= 1'b0;
    end else if (base_tick) begin
      if (rate_count_reg == 16'h0000) begin
        rate_count_reg <= reload_value;
        bit_rate_tick <= 1'b1;
      end else begin
        rate_count_reg <= rate_count_reg - 16'h0001;
        bit_rate_tick <= 1'b0;
      end
    end else begin
      bit_rate_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake-on-break monitor

  assign wake_event = (wake_state_reg == autobaud_pkg::wake_wait_fall) && line_fall;
  assign break_end = (wake_state_reg == autobaud_pkg::wake_wait_rise) && line_rise;

  // Armed: wait for the break start, then for its end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_state_reg <= autobaud_pkg::wake_off;
    end else if (!wake_on_break_enable_reg) begin
      wake_state_reg <= autobaud_pkg::wake_off;
    end else begin
      case (wake_state_reg)
        autobaud_pkg::wake_off: begin
          wake_state_reg <= autobaud_pkg::wake_wait_fall;
        end
        autobaud_pkg::wake_wait_fall: begin
          if (wake_event) begin
            wake_state_reg <= autobaud_pkg::wake_wait_rise;
          end
        end
        autobaud_pkg::wake_wait_rise: begin
          if (break_end) begin
            wake_state_reg <= autobaud_pkg::wake_off;
          end
        end
        default: begin
          wake_state_reg <= autobaud_pkg::wake_off;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive flag, data and idle status

  // Set wins over a same-cycle read so no event is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      receive_flag <= 1'b0;
    end else if (cal_done || wake_event) begin
      receive_flag <= 1'b1;
    end else if (rx_data_read) begin
      receive_flag <= 1'b0;
    end
  end

  // No character path here; the wake character reads as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      receive_data_reg <= autobaud_pkg::receive_data_reset;
    end else if (wake_event || cal_done) begin
      receive_data_reg <= autobaud_pkg::receive_data_reset;
    end
  end

  // Idle drops from the start bit until calibration ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      receive_idle_flag <= 1'b1;
      receiver_held_idle <= 1'b0;
    end else begin
      receive_idle_flag <= !((cal_state_reg == autobaud_pkg::cal_first_rise)
        || (cal_state_reg == autobaud_pkg::cal_count));
      // Normal reception is suppressed during calibration and while armed
      receiver_held_idle <= autobaud_enable_reg || wake_on_break_enable_reg;
    end
  end

  // Line level only feeds the edge detector outputs
  logic unused_level;
  assign unused_level = line_level;

endmodule : uart_autobaud_wake_on_break
`default_nettype wire

//--- shared/autobaud_pkg.sv
// Package: register map, field positions, reset values and timing constants
package autobaud_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] rate_control_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] divisor_low_off = 8'h08;
  localparam logic [7:0] divisor_high_off = 8'h0C;
  localparam logic [7:0] receive_data_off = 8'h10;

  // Field positions in the rate control register
  localparam int autobaud_enable_bit = 0;
  localparam int wake_on_break_enable_bit = 1;
  localparam int wide_divisor_select_bit = 2;
  localparam int high_speed_select_bit = 3;
  localparam int sync_mode_bit = 4;

  // Field positions in the status register
  localparam int receive_flag_bit = 0;
  localparam int receive_idle_flag_bit = 1;
  localparam int calibrating_bit = 2;

  // Reset values
  localparam logic [4:0] rate_control_reset = 5'h00;
  localparam logic [7:0] divisor_reset = 8'h00;
  localparam logic [7:0] receive_data_reset = 8'h00;

  // Calibration counter starts here on the first rising edge
  localparam logic [15:0] cal_start_count = 16'h0001;
  // Rising edges of the sync character, stop bit edge included
  localparam logic [2:0] sync_rising_edges = 3'h5;

  // Prescaler masks: a tick when all masked bits of the free counter are ones
  localparam logic [8:0] base_mask_div64 = 9'h03F;
  localparam logic [8:0] base_mask_div16 = 9'h00F;
  localparam logic [8:0] base_mask_div4 = 9'h003;
  localparam logic [8:0] cal_mask_div512 = 9'h1FF;
  localparam logic [8:0] cal_mask_div128 = 9'h07F;
  localparam logic [8:0] cal_mask_div32 = 9'h01F;
  localparam logic [8:0] prescale_reset = 9'h000;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    cal_off,
    cal_arm,
    cal_first_rise,
    cal_count
  } cal_state_t;

  // Wake monitor states
  typedef enum logic [1:0] {
    wake_off,
    wake_wait_fall,
    wake_wait_rise
  } wake_state_t;

endpackage : autobaud_pkg

//--- rtl/rate_tick_gen.sv
// Prescaler giving the rate generator base tick and the calibration tick
`timescale 1ns/100ps
`default_nettype none

module rate_tick_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wide_divisor_select,
  input wire logic high_speed_select,
  input wire logic sync_mode,
  output logic base_tick,
  output logic cal_tick
);

  logic [8:0] prescale_reg; // Free running oscillator divider
  logic [8:0] base_mask; // Selected base divide mask
  logic [8:0] cal_mask; // Selected calibration divide mask

  // Mode decode; synchronous mode always uses the fastest base
  always_comb begin
    if (sync_mode || (wide_divisor_select && high_speed_select)) begin
      base_mask = autobaud_pkg::base_mask_div4;
      cal_mask = autobaud_pkg::cal_mask_div32;
    end else if (wide_divisor_select || high_speed_select) begin
      base_mask = autobaud_pkg::base_mask_div16;
      cal_mask = autobaud_pkg::cal_mask_div128;
    end else begin
      base_mask = autobaud_pkg::base_mask_div64;
      cal_mask = autobaud_pkg::cal_mask_div512;
    end
  end

  // Free counter; calibration divide is always eight times the base divide
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale_reg <= autobaud_pkg::prescale_reset;
    end else begin
      prescale_reg <= prescale_reg + 9'h001;
    end
  end

  // Registered one-cycle ticks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_tick <= 1'b0;
      cal_tick <= 1'b0;
    end else begin
      base_tick <= ((prescale_reg & base_mask) == base_mask);
      cal_tick <= ((prescale_reg & cal_mask) == cal_mask);
    end
  end

endmodule : rate_tick_gen
`default_nettype wire

//--- rtl/line_edge_detect.sv
// Edge detector for the serial input line
`timescale 1ns/100ps
`default_nettype none

module line_edge_detect (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_in_line,
  output logic line_level,
  output logic line_rise,
  output logic line_fall
);

  logic prev_reg; // Line level one cycle back

  // Idle line is high, so reset to high to avoid a false fall
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= serial_in_line;
    end
  end

  // Combinational edges from the current and previous sample
  assign line_level = prev_reg;
  assign line_rise = serial_in_line && !prev_reg;
  assign line_fall = !serial_in_line && prev_reg;

endmodule : line_edge_detect
`default_nettype wire

//--- test/autobaud_monitor.sv
// Checker of port timing for the auto-baud and wake-on-break block
`timescale 1ns/100ps
`default_nettype none

module autobaud_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_line,
  input wire logic receive_flag,
  input wire logic receive_idle_flag,
  input wire logic receiver_held_idle,
  input wire logic bit_rate_tick
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: setup phase, mapped address, completed read of receive data
  logic setup;
  logic mapped;
  logic data_read;
  assign setup = psel && !penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h10);
  assign data_read = psel && penable && pready && !pwrite && (paddr == 8'h10);

  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_after_setup: assert property (setup |=> pready && psel && penable)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("error on mapped access");
  chk_data_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_flag_holds: assert property (receive_flag && !data_read |=> receive_flag)
    else $error("flag dropped without read");
  chk_flag_read_clear: assert property (data_read && receive_flag && $stable(serial_in_line)
    && $past(serial_in_line) == $past(serial_in_line, 2) |=> !receive_flag)
    else $error("flag not cleared by data read");
  chk_flag_line_cause: assert property ($rose(receive_flag) |->
    $past(serial_in_line) != $past(serial_in_line, 2)
    || $past(serial_in_line, 2) != $past(serial_in_line, 3)
    || $past(serial_in_line, 3) != $past(serial_in_line, 4))
    else $error("flag rose without a line edge");
  chk_measure_held: assert property (!receive_idle_flag |-> receiver_held_idle)
    else $error("measuring while receiver not held");
  chk_tick_spacing: assert property (bit_rate_tick |=> !bit_rate_tick [*3])
    else $error("rate ticks closer than four cycles");

  // Main scenarios seen at all
  cover property ($rose(receive_flag));
  cover property ($fell(receive_idle_flag));
  cover property (pslverr);
endmodule : autobaud_monitor

bind uart_autobaud_wake_on_break autobaud_monitor mon (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_in_line(serial_in_line),
  .receive_flag(receive_flag), .receive_idle_flag(receive_idle_flag),
  .receiver_held_idle(receiver_held_idle), .bit_rate_tick(bit_rate_tick));

`default_nettype wire

//--- test/serial_node.sv
// Remote serial node model driving the serial input line
`timescale 1ns/100ps
`default_nettype none

module serial_node (
  input wire logic clk_sys,
  output logic serial_in_line
);
  // Line idles high between frames
  initial serial_in_line = 1'b1;

  // Hold a level for a whole number of cycles, changed just after an edge
  task automatic hold_line(input logic lvl, input int cycles);
    @(posedge clk_sys);
    serial_in_line <= lvl;
    repeat (cycles - 1) @(posedge clk_sys);
  endtask : hold_line

  // Start bit, eight data bits first bit lowest, stop bit
  task automatic send_char(input logic [7:0] b, input int bc);
    hold_line(1'b0, bc);
    for (int i = 0; i < 8; i++) begin
      hold_line(b[i], bc);
    end
    hold_line(1'b1, bc);
  endtask : send_char

  // All-zero break so no fragment follows the wake event
  task automatic send_break(input int bits, input int bc);
    hold_line(1'b0, bits * bc);
    hold_line(1'b1, bc);
  endtask : send_break
endmodule : serial_node

`default_nettype wire

//--- test/tb_uart_autobaud_wake_on_break.sv
// Testbench for auto-baud calibration and wake-on-break over APB
`timescale 1ns/100ps
`default_nettype none

module tb_uart_autobaud_wake_on_break;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic serial_in_line, receive_flag, receive_idle_flag, receiver_held_idle, bit_rate_tick;
  int errors, total_checks, n, ex;
  // Per mode: control bits, calibration divide, bit length in cycles
  logic [31:0] cmode [4] = '{32'h0, 32'h8, 32'h4, 32'hC};
  int caldiv [4] = '{512, 128, 128, 32};
  int bitc [4] = '{1024, 4352, 256, 64};

  serial_node node (.clk_sys(clk_sys), .serial_in_line(serial_in_line));
  uart_autobaud_wake_on_break dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_line(serial_in_line),
    .receive_flag(receive_flag), .receive_idle_flag(receive_idle_flag),
    .receiver_held_idle(receiver_held_idle), .bit_rate_tick(bit_rate_tick));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // Compare, optionally allowing one more than expected (tick phase is free)
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol,
                       input string what);
    total_checks++;
    if (got !== exp && !(tol > 0 && got === exp + 32'h1)) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; request held until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Wait for ready however long it takes; the hang guard bounds it
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input int tol,
                        input string what);
    xfer(a, 1'b0, 32'h0);
    check(rdv, exp, tol, what);
    check(err, 32'h0, 0, "error flag");
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values and refused address
    rd_chk(autobaud_pkg::rate_control_off, 32'h0, 0, "ctrl reset");
    rd_chk(autobaud_pkg::status_off, 32'h2, 0, "status reset");
    rd_chk(autobaud_pkg::divisor_low_off, 32'h0, 0, "low reset");
    rd_chk(autobaud_pkg::divisor_high_off, 32'h0, 0, "high reset");
    xfer(8'h14, 1'b0, 32'h0);
    check(err, 32'h1, 0, "unmapped error");
    check(rdv, 32'h0, 0, "unmapped data");
    // Calibration in every rate mode
    for (int i = 0; i < 4; i++) begin
      wr(autobaud_pkg::rate_control_off, cmode[i] | 32'h1);
      repeat (4) @(posedge clk_sys);
      check(receiver_held_idle, 32'h1, 0, "held idle");
      node.send_char(8'h55, bitc[i]);
      repeat (4) @(posedge clk_sys);
      check(receive_flag, 32'h1, 0, "flag after sync");
      rd_chk(autobaud_pkg::rate_control_off, cmode[i], 0, "enable cleared");
      ex = 8 * bitc[i] / caldiv[i];
      rd_chk(autobaud_pkg::divisor_low_off, ex & 255, 1, "count low");
      rd_chk(autobaud_pkg::divisor_high_off, ex >> 8, 0, "count high");
      rd_chk(autobaud_pkg::receive_data_off, 32'h0, 0, "data read");
      // Flag clears at the read's closing edge; look one edge later
      @(posedge clk_sys);
      check(receive_flag, 32'h0, 0, "flag cleared");
    end
    // Plain wake on a falling edge, cleared by the following rise
    rd_chk(autobaud_pkg::status_off, 32'h2, 0, "idle before wake");
    wr(autobaud_pkg::rate_control_off, 32'h2);
    repeat (3) @(posedge clk_sys);
    check(receiver_held_idle, 32'h1, 0, "wake held idle");
    node.hold_line(1'b0, 6);
    check(receive_flag, 32'h1, 0, "wake flag");
    rd_chk(autobaud_pkg::rate_control_off, 32'h2, 0, "wake still set");
    node.hold_line(1'b1, 6);
    rd_chk(autobaud_pkg::rate_control_off, 32'h0, 0, "wake cleared");
    rd_chk(autobaud_pkg::receive_data_off, 32'h0, 0, "wake data read");
    @(posedge clk_sys);
    check(receive_flag, 32'h0, 0, "wake flag cleared");
    // Wake refused in synchronous mode
    wr(autobaud_pkg::rate_control_off, 32'h12);
    rd_chk(autobaud_pkg::rate_control_off, 32'h10, 0, "sync wake");
    // Leave synchronous mode first: wake is forced off while it is set
    wr(autobaud_pkg::rate_control_off, 32'h0);
    // Break then sync: calibrate on the character after the break
    wr(autobaud_pkg::rate_control_off, 32'hF);
    repeat (4) @(posedge clk_sys);
    node.send_break(13, 64);
    check(receive_flag, 32'h1, 0, "break flag");
    rd_chk(autobaud_pkg::rate_control_off, 32'hD, 0, "after break");
    rd_chk(autobaud_pkg::receive_data_off, 32'h0, 0, "break data read");
    node.send_char(8'h55, 64);
    repeat (4) @(posedge clk_sys);
    rd_chk(autobaud_pkg::divisor_low_off, 32'h10, 1, "count after break");
    rd_chk(autobaud_pkg::rate_control_off, 32'hC, 0, "after sync");
    rd_chk(autobaud_pkg::receive_data_off, 32'h0, 0, "sync data read");
    // Bit period in wide fast mode: four times divisor plus one
    wr(autobaud_pkg::divisor_low_off, 32'h3);
    wr(autobaud_pkg::divisor_high_off, 32'h0);
    n = 0;
    while (bit_rate_tick !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    n = 1;
    while (bit_rate_tick !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check(n, 32'd16, 0, "bit period");
    summarize();
  end
endmodule : tb_uart_autobaud_wake_on_break

`default_nettype wire
